// ### core/rcc_pkg.sv
package rcc_pkg;

  // Reset sequencer states
  typedef enum logic [0:0] {
    RCC_RUN = 1'b0,
    RCC_HOLD = 1'b1
  } rcc_state_t;

  // Request lines from pin, supply monitors and processor core
  typedef struct packed {
    logic ext_pin_n;
    logic watchdog_timeout;
    logic cpu_sleep;
    logic brown_out_reset;
    logic trap_hard;
    logic trap_soft;
    logic illegal_opcode;
    logic reset_instr;
  } rcc_src_t;

  // Avalon-MM request bundle
  typedef struct packed {
    logic [7:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
  } rcc_avs_req_t;

endpackage : rcc_pkg

// ### core/rcc_regs.svh
`ifndef RCC_REGS_SVH
`define RCC_REGS_SVH

// Register byte offsets on the Avalon-MM slave
`define RCC_OFF_REASON 8'h00
`define RCC_OFF_MASK 8'h04
`define RCC_OFF_CTRL 8'h08
`define RCC_OFF_KEY 8'h0C
`define RCC_OFF_CFG 8'h10
`define RCC_OFF_STATE 8'h14

// Reason flag positions, shared by REASON and MASK
`define RCC_BIT_PIN 0
`define RCC_BIT_POR 1
`define RCC_BIT_WDOG 2
`define RCC_BIT_BROWN 3
`define RCC_BIT_CFG 4
`define RCC_BIT_SOFT 5
`define RCC_BIT_TRAP 6
`define RCC_BIT_ILLOP 7
`define RCC_NUM_SRC 8

// CTRL fields
`define RCC_CTRL_REGEN 0
`define RCC_CTRL_CLK_LO 4
`define RCC_CTRL_CLK_HI 7

// Reset values
`define RCC_RST_REASON 8'h02
`define RCC_RST_MASK 8'h00
`define RCC_RST_REGEN 1'b1
`define RCC_RST_CLKSEL 4'h0
`define RCC_RST_CFG 8'h00

// Software reset key sequence, written to KEY in this order
`define RCC_KEY_FIRST 32'h0000_AA99
`define RCC_KEY_SECOND 32'h0000_5566

// Reset pulse length
`define RCC_CLK_NS 8
`define RCC_HOLD_NS 128
`define RCC_HOLD_CYC ((`RCC_HOLD_NS + `RCC_CLK_NS - 1) / `RCC_CLK_NS)

`endif

// ### core/rcc_reset_cause.sv
// Summary of operation
// - A low external reset pin asserts system reset and sets the pin reason flag.
// - A pin reset leaves the selected clock source untouched.
// - Power-on produces an internal reset pulse and sets the power-on reason flag.
// - A watchdog time-out while running asserts reset and keeps the clock source.
// - A watchdog time-out in sleep or idle only wakes the processor.
// - Brown-out causes a reset only while the regulator is enabled.
// - Each configuration bit is stored with a complementary shadow bit.
// - Value and shadow are compared every cycle and a mismatch resets the device.
// - A reset instruction or key sequence asserts reset without touching the clock.
// - A hard and a soft trap in the same cycle cause a trap-conflict reset.
// - An illegal opcode fetch causes a reset.
// - Any request asserts reset at once, waiting for nothing pending.
// - Each source has a readable reason flag.
// - Reason flags clear singly, in groups or all by write-one, others keep their value.
// - Sources not built in a variant have no flag and are never reported.
// - Hardware sets the matching flag on reset and it stays until software or a power-on reset clears it.
`include "rcc_regs.svh"
`timescale 1ns/100ps
`default_nettype none

module rcc_reset_cause
  import rcc_pkg::*;
#(
  parameter int CFG_W = 8,
  parameter logic [`RCC_NUM_SRC-1:0] SRC_EN = 8'hFF,
  parameter int HOLD_CYC = `RCC_HOLD_CYC
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire rcc_avs_req_t avs_req,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire rcc_src_t src,
  input wire logic [CFG_W-1:0] cfg_upset,
  output logic sys_rst_n,
  output logic [3:0] clk_sel,
  output logic [CFG_W-1:0] cfg_value,
  output logic cpu_wake,
  output logic irq
);

  localparam int CW = $clog2(HOLD_CYC + 1);

  // Parameter limits
  generate
    if (CFG_W < 1 || CFG_W > 32) begin : g_bad_cfg
      $error("CFG_W must be 1 to 32");
    end
    if (HOLD_CYC < 1) begin : g_bad_hold
      $error("HOLD_CYC must be at least 1");
    end
    if (SRC_EN[`RCC_BIT_POR] == 1'b0) begin : g_bad_por
      $error("power-on source cannot be left out");
    end
  endgenerate

  // Whole state of the block
  typedef struct packed {
    rcc_state_t state;
    logic [CW-1:0] cnt;
    logic rst_n;
    logic [`RCC_NUM_SRC-1:0] reason;
    logic [`RCC_NUM_SRC-1:0] mask;
    logic reg_en;
    logic [3:0] clk_sel;
    logic [CFG_W-1:0] cfg_val;
    logic [CFG_W-1:0] cfg_shd;
    logic key_armed;
    logic wreq;
    logic [31:0] rdata;
    logic wake;
    logic irq;
  } rcc_core_t;

  rcc_core_t q;
  rcc_core_t d;

  // Address match, used by the read mux and the write decode
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
    hit = (addr == off);
  endfunction : hit

  logic wr_fire;
  logic req_any;
  logic mismatch;
  logic key_seq;
  logic [`RCC_NUM_SRC-1:0] ev;
  logic [`RCC_NUM_SRC-1:0] clr;
  logic [31:0] rd_mux;

  // Bus request decode; write acts at the edge that ends the waitrequest-low cycle
  assign req_any = avs_req.read | avs_req.write;
  assign wr_fire = avs_req.write & ~q.wreq;

  // Any pair that is not opposite is a mismatch
  assign mismatch = ~&(q.cfg_val ^ q.cfg_shd);

  // Second key after the first, with no other KEY write between, completes the software reset sequence
  assign key_seq = wr_fire & hit(avs_req.address, `RCC_OFF_KEY) & q.key_armed &
                   (avs_req.writedata == `RCC_KEY_SECOND);

  // Reset request per source, gated by the variant's source set
  always_comb begin
    ev = '0;
    ev[`RCC_BIT_PIN] = ~src.ext_pin_n;
    ev[`RCC_BIT_WDOG] = src.watchdog_timeout & ~src.cpu_sleep;
    ev[`RCC_BIT_BROWN] = src.brown_out_reset & q.reg_en;
    ev[`RCC_BIT_CFG] = mismatch;
    ev[`RCC_BIT_SOFT] = src.reset_instr | key_seq;
    ev[`RCC_BIT_TRAP] = src.trap_hard & src.trap_soft;
    ev[`RCC_BIT_ILLOP] = src.illegal_opcode;
    ev = ev & SRC_EN;
  end

  // Read data mux; unmapped addresses read zero
  always_comb begin
    rd_mux = '0;
    if (hit(avs_req.address, `RCC_OFF_REASON)) begin
      rd_mux[`RCC_NUM_SRC-1:0] = q.reason;
    end else if (hit(avs_req.address, `RCC_OFF_MASK)) begin
      rd_mux[`RCC_NUM_SRC-1:0] = q.mask;
    end else if (hit(avs_req.address, `RCC_OFF_CTRL)) begin
      rd_mux[`RCC_CTRL_REGEN] = q.reg_en;
      rd_mux[`RCC_CTRL_CLK_HI:`RCC_CTRL_CLK_LO] = q.clk_sel;
    end else if (hit(avs_req.address, `RCC_OFF_KEY)) begin
      rd_mux[0] = q.key_armed;
    end else if (hit(avs_req.address, `RCC_OFF_CFG)) begin
      rd_mux[CFG_W-1:0] = q.cfg_val;
    end else if (hit(avs_req.address, `RCC_OFF_STATE)) begin
      rd_mux[0] = ~q.rst_n;
      rd_mux[1] = mismatch;
    end
  end

  // Write-one-to-clear selection of reason flags
  assign clr = (wr_fire && hit(avs_req.address, `RCC_OFF_REASON)) ?
               avs_req.writedata[`RCC_NUM_SRC-1:0] : '0;

  // Next state
  always_comb begin
    d = q;

    // Waitrequest drops for one cycle per request, read data captured with it
    if (req_any && q.wreq) begin
      d.wreq = 1'b0;
      d.rdata = rd_mux;
    end else begin
      d.wreq = 1'b1;
    end

    // Flags are sticky; a set in the clearing cycle wins
    d.reason = ((q.reason & ~clr) | ev) & SRC_EN;

    // Register writes
    if (wr_fire && hit(avs_req.address, `RCC_OFF_MASK)) begin
      d.mask = avs_req.writedata[`RCC_NUM_SRC-1:0] & SRC_EN;
    end
    if (wr_fire && hit(avs_req.address, `RCC_OFF_CTRL)) begin
      d.reg_en = avs_req.writedata[`RCC_CTRL_REGEN];
      d.clk_sel = avs_req.writedata[`RCC_CTRL_CLK_HI:`RCC_CTRL_CLK_LO];
    end
    if (wr_fire && hit(avs_req.address, `RCC_OFF_CFG)) begin
      d.cfg_val = avs_req.writedata[CFG_W-1:0];
      d.cfg_shd = ~avs_req.writedata[CFG_W-1:0];
    end
    // Storage upsets flip shadow bits and are caught by the compare
    d.cfg_shd = d.cfg_shd ^ cfg_upset;

    // Key sequence: first key arms, any other key write disarms
    if (wr_fire && hit(avs_req.address, `RCC_OFF_KEY)) begin
      d.key_armed = (avs_req.writedata == `RCC_KEY_FIRST);
    end

    // Reset sequencer; clk_sel is never touched here
    case (q.state)
      RCC_RUN: begin
        if (|ev) begin
          d.state = RCC_HOLD;
          d.cnt = CW'(HOLD_CYC - 1);
          d.rst_n = 1'b0;
        end
      end
      RCC_HOLD: begin
        if (|ev) begin
          d.cnt = CW'(HOLD_CYC - 1);
        end else if (q.cnt == '0) begin
          d.state = RCC_RUN;
          d.rst_n = 1'b1;
        end else begin
          d.cnt = q.cnt - 1'b1;
        end
      end
      default: begin
        d.state = RCC_HOLD;
        d.cnt = CW'(HOLD_CYC - 1);
        d.rst_n = 1'b0;
      end
    endcase

    // Time-out in sleep or idle wakes instead of resetting
    d.wake = src.watchdog_timeout & src.cpu_sleep & SRC_EN[`RCC_BIT_WDOG];

    // Level interrupt from unmasked flags
    d.irq = |(d.reason & d.mask);
  end

  // State register; rst_b is the power-on reset with an internal pulse
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      q.state <= RCC_HOLD;
      q.cnt <= CW'(HOLD_CYC - 1);
      q.rst_n <= 1'b0;
      q.reason <= `RCC_RST_REASON;
      q.mask <= `RCC_RST_MASK;
      q.reg_en <= `RCC_RST_REGEN;
      q.clk_sel <= `RCC_RST_CLKSEL;
      q.cfg_val <= CFG_W'(`RCC_RST_CFG);
      q.cfg_shd <= ~CFG_W'(`RCC_RST_CFG);
      q.key_armed <= 1'b0;
      q.wreq <= 1'b1;
      q.rdata <= '0;
      q.wake <= 1'b0;
      q.irq <= 1'b0;
    end else begin
      q <= d;
    end
  end

  // Outputs straight from the state register
  assign avs_readdata = q.rdata;
  assign avs_waitrequest = q.wreq;
  assign sys_rst_n = q.rst_n;
  assign clk_sel = q.clk_sel;
  assign cfg_value = q.cfg_val;
  assign cpu_wake = q.wake;
  assign irq = q.irq;

endmodule : rcc_reset_cause

`default_nettype wire

// ### tb/rcc_monitor.sv
`include "rcc_regs.svh"
`timescale 1ns/100ps
`default_nettype none
module rcc_monitor
  import rcc_pkg::*;
#(parameter int CFG_W = 8, parameter int HOLD_CYC = 16) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire rcc_avs_req_t avs_req,
  input wire logic avs_waitrequest,
  input wire rcc_src_t src,
  input wire logic [CFG_W-1:0] cfg_upset,
  input wire logic sys_rst_n,
  input wire logic [3:0] clk_sel,
  input wire logic cpu_wake
);
  int low_q;
  // Counts cycles of held system reset
  always_ff @(posedge sys_clk or negedge rst_b)
    if (!rst_b) low_q <= 0;
    else low_q <= sys_rst_n ? 0 : low_q + 1;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  sequence s_req; (avs_req.read || avs_req.write) && avs_waitrequest; endsequence
  sequence s_ans; !avs_waitrequest ##1 avs_waitrequest; endsequence
  a_bus_answer: assert property (s_req |=> s_ans) else $error("bus answer");
  a_pin_reset: assert property (!src.ext_pin_n |=> !sys_rst_n) else $error("pin");
  a_wdog_run: assert property (src.watchdog_timeout && !src.cpu_sleep |=> !sys_rst_n)
    else $error("wdog");
  a_wdog_wake: assert property (src.watchdog_timeout && src.cpu_sleep |=> cpu_wake)
    else $error("wake");
  a_trap_pair: assert property (src.trap_hard && src.trap_soft |=> !sys_rst_n)
    else $error("trap");
  a_illop_reset: assert property (src.illegal_opcode |=> !sys_rst_n) else $error("illop");
  a_instr_reset: assert property (src.reset_instr |=> !sys_rst_n) else $error("instr");
  a_cfg_mismatch: assert property (|cfg_upset |-> ##[1:2] !sys_rst_n) else $error("cfg");
  a_clk_kept: assert property (!(avs_req.write && avs_req.address == `RCC_OFF_CTRL)
    |=> $stable(clk_sel)) else $error("clk_sel");
  a_hold_len: assert property ($rose(sys_rst_n) |-> low_q >= HOLD_CYC) else $error("hold");
endmodule : rcc_monitor
bind rcc_reset_cause rcc_monitor #(.CFG_W(CFG_W), .HOLD_CYC(HOLD_CYC)) u_mon (
  .sys_clk(sys_clk), .rst_b(rst_b), .avs_req(avs_req), .avs_waitrequest(avs_waitrequest),
  .src(src), .cfg_upset(cfg_upset), .sys_rst_n(sys_rst_n), .clk_sel(clk_sel),
  .cpu_wake(cpu_wake));
`default_nettype wire

// ### tb/rcc_src_model.sv
`timescale 1ns/100ps
`default_nettype none
module rcc_src_model
  import rcc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire rcc_src_t req,
  output rcc_src_t src
);
  // Pin, supplies and core drive levels; pin idles high on its pull-up
  always_ff @(posedge sys_clk or negedge rst_b)
    if (!rst_b) src <= '{ext_pin_n: 1'b1, default: 1'b0};
    else src <= req;
endmodule : rcc_src_model
`default_nettype wire

// ### tb/tb_rcc_reset_cause.sv
`include "rcc_regs.svh"
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, a) begin tests_run++; if ((a) !== (e)) begin err_total++; \
  $display("[ERR] %s exp %0h got %0h", n, e, a); end end
module tb_rcc_reset_cause
  import rcc_pkg::*;
;
  localparam rcc_src_t IDLE = '{ext_pin_n: 1'b1, default: 1'b0};
  localparam logic [7:0] BITS [6] = '{8'h01, 8'h04, 8'h08, 8'h40, 8'h80, 8'h20};
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  rcc_avs_req_t req = '0;
  rcc_src_t sreq = IDLE;
  rcc_src_t src;
  logic [7:0] upset = 8'h00;
  logic [31:0] rd;
  logic [31:0] q;
  logic [3:0] clk_sel;
  logic [7:0] cfgv;
  logic waitreq, sys_rst_n, wake, irq, wk;
  int err_total = 0;
  int tests_run = 0;
  int cyc = 0;
  rcc_src_t s;
  always #4 sys_clk = ~sys_clk;
  rcc_src_model u_src (.sys_clk(sys_clk), .rst_b(rst_b), .req(sreq), .src(src));
  rcc_reset_cause #(.HOLD_CYC(4)) uut (.sys_clk(sys_clk), .rst_b(rst_b), .avs_req(req),
    .avs_readdata(rd), .avs_waitrequest(waitreq), .src(src), .cfg_upset(upset),
    .sys_rst_n(sys_rst_n), .clk_sel(clk_sel), .cfg_value(cfgv), .cpu_wake(wake), .irq(irq));
  task automatic results();
    $display("checks %0d errors %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : results
  // Cuts a hang short
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      results();
    end
  end
  // One Avalon access, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    req <= '{a, !w, w, d};
    do begin @(posedge sys_clk); end while (waitreq !== 1'b0);
    q = rd;
    req <= '0;
    @(posedge sys_clk);
  endtask : bus
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    `CHK("readdata", e, q)
  endtask : rdc
  task automatic up();
    while (sys_rst_n !== 1'b1) @(posedge sys_clk);
  endtask : up
  // Drives one request for one cycle, looks at reset and wake when they land
  task automatic fire(input rcc_src_t v, input logic lo);
    sreq <= v;
    @(posedge sys_clk);
    sreq <= IDLE;
    @(posedge sys_clk);
    #1 `CHK("sys_rst_n", !lo, sys_rst_n)
    wk = wake;
    @(posedge sys_clk);
    up();
  endtask : fire
  task automatic t_sources();
    logic [7:0] exp;
    exp = 8'h02;
    bus(1'b1, `RCC_OFF_CTRL, 32'h51);
    for (int i = 0; i < 6; i++) begin
      s = IDLE;
      case (i)
        0: s.ext_pin_n = 1'b0;
        1: s.watchdog_timeout = 1'b1;
        2: s.brown_out_reset = 1'b1;
        3: begin s.trap_hard = 1'b1; s.trap_soft = 1'b1; end
        4: s.illegal_opcode = 1'b1;
        default: s.reset_instr = 1'b1;
      endcase
      fire(s, 1'b1);
      exp = exp | BITS[i];
      rdc(`RCC_OFF_REASON, {24'h0, exp});
      `CHK("clk_sel", 4'h5, clk_sel)
    end
    bus(1'b1, `RCC_OFF_REASON, 32'h20);
    rdc(`RCC_OFF_REASON, 32'hCF);
    bus(1'b1, `RCC_OFF_KEY, `RCC_KEY_FIRST);
    bus(1'b1, `RCC_OFF_KEY, `RCC_KEY_SECOND);
    repeat (2) @(posedge sys_clk);
    up();
    rdc(`RCC_OFF_REASON, 32'hEF);
  endtask : t_sources
  task automatic t_clear_irq();
    bus(1'b1, `RCC_OFF_MASK, 32'h80);
    `CHK("irq", 1'b1, irq)
    bus(1'b1, `RCC_OFF_REASON, 32'h03);
    rdc(`RCC_OFF_REASON, 32'hEC);
    bus(1'b1, `RCC_OFF_REASON, 32'hFF);
    rdc(`RCC_OFF_REASON, 32'h00);
    `CHK("irq", 1'b0, irq)
    bus(1'b1, 8'h3C, 32'hFFFFFFFF);
    rdc(8'h3C, 32'h0);
  endtask : t_clear_irq
  task automatic t_refuse();
    s = IDLE;
    s.watchdog_timeout = 1'b1;
    s.cpu_sleep = 1'b1;
    fire(s, 1'b0);
    `CHK("cpu_wake", 1'b1, wk)
    bus(1'b1, `RCC_OFF_CTRL, 32'h50);
    s = IDLE;
    s.brown_out_reset = 1'b1;
    fire(s, 1'b0);
    s = IDLE;
    s.trap_hard = 1'b1;
    fire(s, 1'b0);
    rdc(`RCC_OFF_REASON, 32'h0);
  endtask : t_refuse
  task automatic t_cfg();
    bus(1'b1, `RCC_OFF_CFG, 32'hA5);
    rdc(`RCC_OFF_CFG, 32'hA5);
    `CHK("cfg_value", 8'hA5, cfgv)
    upset <= 8'h10;
    @(posedge sys_clk);
    upset <= 8'h00;
    repeat (3) @(posedge sys_clk);
    upset <= 8'h10;
    @(posedge sys_clk);
    upset <= 8'h00;
    repeat (2) @(posedge sys_clk);
    up();
    rdc(`RCC_OFF_REASON, 32'h10);
  endtask : t_cfg
  task automatic t_rerst();
    rst_b <= 1'b0;
    @(posedge sys_clk);
    rst_b <= 1'b1;
    @(posedge sys_clk);
    #1 `CHK("sys_rst_n", 1'b0, sys_rst_n)
    @(posedge sys_clk);
    up();
    rdc(`RCC_OFF_REASON, 32'h02);
    `CHK("clk_sel", 4'h0, clk_sel)
  endtask : t_rerst
  // Main sequence
  initial begin
    repeat (6) @(posedge sys_clk);
    t_rerst();
    t_sources();
    t_clear_irq();
    t_refuse();
    t_cfg();
    t_rerst();
    results();
  end
endmodule : tb_rcc_reset_cause
`default_nettype wire
